/* File: inc/hpms_pkg.sv */
// constants for the host-port mailbox and status block
// Contract
// - status word reaches the host port only; CPU has no read path.
// - status read starts no internal memory cycle.
// - bit 15 is one while bus supply exceeds 4.4 V.
// - bit 14 follows the identification pin level.
// - bits 12 and 10 flag frame-start or packet-end on engines 2 and 1.
// - bits 9 and 1 flag bus reset on engines 2 and 1.
// - bit 8 set by host mailbox write, cleared by CPU mailbox read.
// - bits 7 and 6 flag resume on engines 2 and 1.
// - bits 5 and 4 set by doorbell writes, cleared by host status read.
// - bits 3 and 2 flag packet done or endpoint events per engine.
// - bit 0 set by CPU mailbox write, cleared by host mailbox read.
// - mailbox holds the last sixteen-bit message written by host or CPU; a host write wins a collision.
// - doorbell write data is never stored.
// - doorbell write sets its flag and raises the host interrupt.
// - CPU mailbox write raises host interrupt; host mailbox read drops it.
package hpms_pkg;
	localparam logic [15:0] OFS_ENGINE1_DOORBELL = 16'h0144;
	localparam logic [15:0] OFS_ENGINE2_DOORBELL = 16'h0148;
	localparam logic [15:0] OFS_SHARED_MAILBOX   = 16'hC0C6;
	localparam logic [15:0] MAILBOX_RST          = 16'h0000;

	// status word bit positions
	localparam int BIT_VBUS      = 15;
	localparam int BIT_ID        = 14;
	localparam int BIT_RSV13     = 13;
	localparam int BIT_SOF2      = 12;
	localparam int BIT_RSV11     = 11;
	localparam int BIT_SOF1      = 10;
	localparam int BIT_BUSRESET2 = 9;
	localparam int BIT_MBX_IN    = 8;
	localparam int BIT_WAKEUP2   = 7;
	localparam int BIT_WAKEUP1   = 6;
	localparam int BIT_DOORBELL2 = 5;
	localparam int BIT_DOORBELL1 = 4;
	localparam int BIT_DONE2     = 3;
	localparam int BIT_DONE1     = 2;
	localparam int BIT_BUSRESET1 = 1;
	localparam int BIT_MBX_OUT   = 0;

	// index of each engine event into the event vectors
	localparam int EV_SOF1      = 0;
	localparam int EV_SOF2      = 1;
	localparam int EV_BUSRESET1 = 2;
	localparam int EV_BUSRESET2 = 3;
	localparam int EV_WAKEUP1   = 4;
	localparam int EV_WAKEUP2   = 5;
	localparam int EV_DONE1     = 6;
	localparam int EV_DONE2     = 7;
	localparam int EV_COUNT     = 8;

	localparam logic RESERVED_VAL = 1'b0;
	localparam logic FLAG_RST     = 1'b0;
endpackage

/* File: core/hpms_status.sv */
// host-port mailbox, doorbells and status word
`timescale 1ns/1ps
module hpms_status #(
	parameter int DW = 16
) (
	input  wire logic                            clk,
	input  wire logic                            nrst,
	input  wire logic                            hp_stat_rd,
	input  wire logic                            hp_mbx_rd,
	input  wire logic                            hp_mbx_wr,
	input  wire logic [DW-1:0]                   hp_wdata,
	output logic      [DW-1:0]                   hp_rdata,
	output logic                                 hp_rvalid,
	output logic                                 hp_mem_cycle,
	output logic                                 host_port_irq,
	input  wire logic                            cpu_wr,
	input  wire logic                            cpu_rd,
	input  wire logic [15:0]                     cpu_addr,
	input  wire logic [DW-1:0]                   cpu_wdata,
	output logic      [DW-1:0]                   cpu_rdata,
	input  wire logic                            vbus_valid,
	input  wire logic                            id_level,
	input  wire logic [hpms_pkg::EV_COUNT-1:0]   ev_set,
	input  wire logic [hpms_pkg::EV_COUNT-1:0]   ev_ack
);
	logic [DW-1:0]                 mailbox;
	logic                          mbx_in_flag;
	logic                          mbx_out_flag;
	logic                          engine1_doorbell_flag;
	logic                          engine2_doorbell_flag;
	wire  [hpms_pkg::EV_COUNT-1:0] ev_flag;
	logic                          vbus_q;
	logic                          id_q;
	logic [DW-1:0]                 next_status;

	function automatic logic cpu_hit(input logic [15:0] a, input logic [15:0] ofs);
		return a == ofs;
	endfunction

	wire cpu_mbx_wr = cpu_wr && cpu_hit(cpu_addr, hpms_pkg::OFS_SHARED_MAILBOX);
	wire cpu_mbx_rd = cpu_rd && cpu_hit(cpu_addr, hpms_pkg::OFS_SHARED_MAILBOX);
	wire cpu_db1_wr = cpu_wr && cpu_hit(cpu_addr, hpms_pkg::OFS_ENGINE1_DOORBELL);
	wire cpu_db2_wr = cpu_wr && cpu_hit(cpu_addr, hpms_pkg::OFS_ENGINE2_DOORBELL);
	// status read only counts when the mailbox is not also selected
	wire stat_take  = hp_stat_rd && !hp_mbx_rd;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mailbox <= hpms_pkg::MAILBOX_RST;
		end else if (hp_mbx_wr) begin
			mailbox <= hp_wdata;
		end else if (cpu_mbx_wr) begin
			mailbox <= cpu_wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mbx_in_flag <= hpms_pkg::FLAG_RST;
		end else if (hp_mbx_wr) begin
			mbx_in_flag <= 1'b1;
		end else if (cpu_mbx_rd) begin
			mbx_in_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mbx_out_flag <= hpms_pkg::FLAG_RST;
		end else if (cpu_mbx_wr) begin
			mbx_out_flag <= 1'b1;
		end else if (hp_mbx_rd) begin
			mbx_out_flag <= 1'b0;
		end
	end

	// doorbell data never stored, only the written event matters
	// doorbell flags, host status read clears
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			engine1_doorbell_flag <= hpms_pkg::FLAG_RST;
			engine2_doorbell_flag <= hpms_pkg::FLAG_RST;
		end else begin
			engine1_doorbell_flag <= cpu_db1_wr || (engine1_doorbell_flag && !stat_take);
			engine2_doorbell_flag <= cpu_db2_wr || (engine2_doorbell_flag && !stat_take);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			host_port_irq <= 1'b0;
		end else if (cpu_mbx_wr || cpu_db1_wr || cpu_db2_wr) begin
			host_port_irq <= 1'b1;
		end else if (hp_mbx_rd) begin
			host_port_irq <= 1'b0;
		end
	end

	// sticky engine events held until acknowledged
	genvar gi;
	generate
		for (gi = 0; gi < hpms_pkg::EV_COUNT; gi++) begin : g_ev
			// one flop per event keeps each process the only writer
			logic held;
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					held <= hpms_pkg::FLAG_RST;
				end else begin
					held <= ev_set[gi] || (held && !ev_ack[gi]);
				end
			end
			assign ev_flag[gi] = held;
		end
	endgenerate

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			vbus_q <= 1'b0;
			id_q   <= 1'b0;
		end else begin
			vbus_q <= vbus_valid;
			id_q   <= id_level;
		end
	end

	always_comb begin
		next_status                          = '0;
		next_status[hpms_pkg::BIT_VBUS]      = vbus_q;
		next_status[hpms_pkg::BIT_ID]        = id_q;
		next_status[hpms_pkg::BIT_RSV13]     = hpms_pkg::RESERVED_VAL;
		next_status[hpms_pkg::BIT_SOF2]      = ev_flag[hpms_pkg::EV_SOF2];
		next_status[hpms_pkg::BIT_RSV11]     = hpms_pkg::RESERVED_VAL;
		next_status[hpms_pkg::BIT_SOF1]      = ev_flag[hpms_pkg::EV_SOF1];
		next_status[hpms_pkg::BIT_BUSRESET2] = ev_flag[hpms_pkg::EV_BUSRESET2];
		next_status[hpms_pkg::BIT_BUSRESET1] = ev_flag[hpms_pkg::EV_BUSRESET1];
		next_status[hpms_pkg::BIT_MBX_IN]    = mbx_in_flag;
		next_status[hpms_pkg::BIT_WAKEUP2]   = ev_flag[hpms_pkg::EV_WAKEUP2];
		next_status[hpms_pkg::BIT_WAKEUP1]   = ev_flag[hpms_pkg::EV_WAKEUP1];
		next_status[hpms_pkg::BIT_DOORBELL2] = engine2_doorbell_flag;
		next_status[hpms_pkg::BIT_DOORBELL1] = engine1_doorbell_flag;
		next_status[hpms_pkg::BIT_DONE2]     = ev_flag[hpms_pkg::EV_DONE2];
		next_status[hpms_pkg::BIT_DONE1]     = ev_flag[hpms_pkg::EV_DONE1];
		next_status[hpms_pkg::BIT_MBX_OUT]   = mbx_out_flag;
	end

	// status only on host data; mailbox read wins a collision
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hp_rdata  <= '0;
			hp_rvalid <= 1'b0;
		end else begin
			hp_rvalid <= hp_stat_rd || hp_mbx_rd;
			if (hp_mbx_rd) begin
				hp_rdata <= mailbox;
			end else if (hp_stat_rd) begin
				hp_rdata <= next_status;
			end
		end
	end

	// only mailbox traffic occupies the memory path
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hp_mem_cycle <= 1'b0;
		end else begin
			hp_mem_cycle <= hp_mbx_rd || hp_mbx_wr;
		end
	end

	// CPU sees the mailbox, never the status word
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cpu_rdata <= '0;
		end else begin
			cpu_rdata <= cpu_mbx_rd ? mailbox : '0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_stat_no_mem;
		stat_take |=> !hp_mem_cycle;
	endproperty
	a_stat_no_mem: assert property (p_stat_no_mem) else $error("status read used memory path");

	property p_vbus_bit;
		hp_stat_rd && !hp_mbx_rd |=> hp_rdata[hpms_pkg::BIT_VBUS] == $past(vbus_q);
	endproperty
	a_vbus_bit: assert property (p_vbus_bit) else $error("vbus bit wrong");

	property p_mbx_in;
		hp_mbx_wr |=> mbx_in_flag ##0 mailbox == $past(hp_wdata);
	endproperty
	a_mbx_in: assert property (p_mbx_in) else $error("incoming message not flagged");

	property p_mbx_in_clr;
		cpu_mbx_rd && !hp_mbx_wr |=> !mbx_in_flag;
	endproperty
	a_mbx_in_clr: assert property (p_mbx_in_clr) else $error("incoming flag not cleared");

	property p_db_clr;
		stat_take && !cpu_db1_wr |=> !engine1_doorbell_flag;
	endproperty
	a_db_clr: assert property (p_db_clr) else $error("doorbell flag survived read");

	property p_db_irq;
		cpu_db2_wr |=> engine2_doorbell_flag && host_port_irq;
	endproperty
	a_db_irq: assert property (p_db_irq) else $error("doorbell did not interrupt");

	property p_irq_drop;
		hp_mbx_rd && !cpu_wr |=> !host_port_irq && !mbx_out_flag;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("irq not dropped");

	property p_ev_hold;
		ev_flag[hpms_pkg::EV_DONE1] && !ev_ack[hpms_pkg::EV_DONE1] |=> ev_flag[hpms_pkg::EV_DONE1];
	endproperty
	a_ev_hold: assert property (p_ev_hold) else $error("event flag lost");

	property p_rsv;
		hp_rvalid && $past(stat_take) |-> !hp_rdata[hpms_pkg::BIT_RSV13] && !hp_rdata[hpms_pkg::BIT_RSV11];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");

	property p_cpu_no_stat;
		cpu_rd && !cpu_mbx_rd |=> cpu_rdata == '0;
	endproperty
	a_cpu_no_stat: assert property (p_cpu_no_stat) else $error("cpu read leaked data");

	c_msg_round: cover property (hp_mbx_wr ##[1:20] cpu_mbx_rd);
	c_out_round: cover property (cpu_mbx_wr ##[1:20] hp_mbx_rd);
	c_db_read:   cover property (cpu_db1_wr ##[1:20] stat_take);
	c_set_clr:   cover property (ev_set[hpms_pkg::EV_SOF2] && ev_ack[hpms_pkg::EV_SOF2]);
endmodule

/* File: tb/hpms_host_model.sv */
// external host processor model on the host port
`timescale 1ns/1ps
module hpms_host_model (
	input  wire logic        clk,
	output logic             hp_stat_rd,
	output logic             hp_mbx_rd,
	output logic             hp_mbx_wr,
	output logic [15:0]      hp_wdata,
	input  wire logic [15:0] hp_rdata,
	input  wire logic        hp_rvalid,
	input  wire logic        hp_mem_cycle
);
	initial begin
		hp_stat_rd = 1'b0;
		hp_mbx_rd  = 1'b0;
		hp_mbx_wr  = 1'b0;
		hp_wdata   = 16'h5A5A;
	end
	// op 0 status read, 1 mailbox read, 2 mailbox write
	task automatic access(input int op, input logic [15:0] d, output logic [15:0] r, output logic v, output logic m);
		@(posedge clk);
		hp_stat_rd <= (op == 0);
		hp_mbx_rd  <= (op == 1);
		hp_mbx_wr  <= (op == 2);
		hp_wdata   <= (op == 2) ? d : ~hp_wdata;
		@(posedge clk);
		hp_stat_rd <= 1'b0;
		hp_mbx_rd  <= 1'b0;
		hp_mbx_wr  <= 1'b0;
		// released data lines flip so stale data never looks valid
		hp_wdata   <= ~hp_wdata;
		// sample once the one-cycle answer has settled, not on its launch edge
		#1;
		r = hp_rdata;
		v = hp_rvalid;
		m = hp_mem_cycle;
		@(posedge clk);
	endtask
	task automatic settle_supply;
		repeat (1000) @(posedge clk);
	endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the host-port mailbox and status block
`timescale 1ns/1ps
module tb_top;
	logic        clk, nrst, hp_stat_rd, hp_mbx_rd, hp_mbx_wr, hp_rvalid, hp_mem_cycle, host_port_irq;
	logic        cpu_wr, cpu_rd, vbus_valid, id_level, v, m;
	logic [15:0] hp_wdata, hp_rdata, cpu_addr, cpu_wdata, cpu_rdata, r, d;
	logic [7:0]  ev_set, ev_ack;
	int          miscompares, num_checks, seed, flags;
	int          evbit[8] = '{10, 12, 1, 9, 6, 7, 2, 3};

	hpms_status i_hpms_status (.clk, .nrst, .hp_stat_rd, .hp_mbx_rd, .hp_mbx_wr, .hp_wdata, .hp_rdata,
		.hp_rvalid, .hp_mem_cycle, .host_port_irq, .cpu_wr, .cpu_rd, .cpu_addr, .cpu_wdata, .cpu_rdata,
		.vbus_valid, .id_level, .ev_set, .ev_ack);
	hpms_host_model i_hpms_host_model (.clk, .hp_stat_rd, .hp_mbx_rd, .hp_mbx_wr, .hp_wdata, .hp_rdata,
		.hp_rvalid, .hp_mem_cycle);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [15:0] stat_exp;
		return {vbus_valid, id_level, 14'h0000} | flags[15:0];
	endfunction

	// status read: one valid pulse, no memory cycle
	task automatic stat;
		logic [15:0] e;
		e = stat_exp();
		i_hpms_host_model.access(0, 16'h0000, r, v, m);
		check({v, m, r}, {2'b10, e});
		flags = flags & ~32'h0030;
	endtask

	task automatic cpu(input logic wr, input logic [15:0] a, input logic [15:0] wd);
		@(posedge clk);
		cpu_wr    <= wr;
		cpu_rd    <= !wr;
		cpu_addr  <= a;
		cpu_wdata <= wd;
		@(posedge clk);
		cpu_wr    <= 1'b0;
		cpu_rd    <= 1'b0;
		cpu_wdata <= ~wd;
		#1;
	endtask

	task automatic pulse(input logic set, input int i);
		@(posedge clk);
		if (set)
			ev_set <= 8'h01 << i;
		else
			ev_ack <= 8'h01 << i;
		@(posedge clk);
		ev_set <= 8'h00;
		ev_ack <= 8'h00;
	endtask

	initial begin
		seed = 32'h8eef6544;
		flags = 0;
		nrst = 1'b0;
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
		cpu_addr = 16'h0000;
		cpu_wdata = 16'h0000;
		vbus_valid = 1'b0;
		id_level = 1'b0;
		ev_set = 8'h00;
		ev_ack = 8'h00;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			vbus_valid <= k[0];
			id_level <= k[1];
			i_hpms_host_model.settle_supply();
			stat();
		end
		for (int i = 0; i < 8; i++) begin
			pulse(1'b1, i);
			flags = flags | (1 << evbit[i]);
			stat();
			stat();
			pulse(1'b0, i);
			flags = flags & ~(1 << evbit[i]);
			stat();
		end
		for (int i = 0; i < 2; i++) begin
			cpu(1'b1, i ? hpms_pkg::OFS_ENGINE2_DOORBELL : hpms_pkg::OFS_ENGINE1_DOORBELL, 16'($random(seed)));
			flags = flags | (16 << i);
			check(host_port_irq, 1'b1);
			stat();
			stat();
		end
		d = 16'($random(seed));
		cpu(1'b1, hpms_pkg::OFS_SHARED_MAILBOX, d);
		flags = flags | 1;
		check(host_port_irq, 1'b1);
		stat();
		i_hpms_host_model.access(1, 16'h0000, r, v, m);
		check({v, m, r}, {2'b11, d});
		check(host_port_irq, 1'b0);
		flags = flags & ~1;
		stat();
		d = 16'($random(seed));
		i_hpms_host_model.access(2, d, r, v, m);
		check({v, m}, 2'b01);
		flags = flags | 32'h0100;
		stat();
		cpu(1'b0, hpms_pkg::OFS_SHARED_MAILBOX, 16'h0000);
		check(cpu_rdata, d);
		flags = flags & ~32'h0100;
		stat();
		cpu(1'b0, hpms_pkg::OFS_ENGINE1_DOORBELL, 16'h0000);
		check(cpu_rdata, 16'h0000);
		// set and acknowledge in one cycle: set wins
		@(posedge clk);
		ev_set <= 8'h02;
		ev_ack <= 8'h02;
		@(posedge clk);
		ev_set <= 8'h00;
		ev_ack <= 8'h00;
		flags = 32'h1000;
		stat();
		cpu(1'b1, hpms_pkg::OFS_SHARED_MAILBOX, 16'($random(seed)));
		// mid-run reset drops flags, read data and interrupt
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		check({host_port_irq, hp_rvalid, hp_rdata}, 18'h00000);
		nrst <= 1'b1;
		flags = 0;
		stat();
		give_verdict();
	end

	// hang guard well beyond the expected run of about 4200 cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		give_verdict();
	end
endmodule
